/* thm_pkg.sv */
// Notes on behaviour
// - open alert when travel above open point
// - open alert holds until below point minus deadband
// - closed alert when travel below closed point
// - closed alert holds until above point plus deadband
// - high-high proximity alert in band, enable bit 9
// - high proximity alert in band, enable bit 10
// - low proximity alert in band, enable bit 11
// - low-low proximity alert in band, enable bit 12
// - reversal counter counts direction reversals
// - reversal counted only outside deadband; reference latched
// - reversal counter cleared by writing zero, unless a counted reversal lands in the same cycle
// - reversal alert above point; cleared by rewrite below
// - accumulate travel change beyond accumulator deadband
// - accumulator reference latched at each increment
// - accumulator cleared by writing zero, unless a sample increments it in the same cycle
// - accumulator alert above point; cleared by rewrite below
// - opening stroke time alert above limit
// - closing stroke time alert above limit
// - diagnostic level selects open/close or demand/reset
// - demand stroke alert above limit at stroke-test level
// - reset stroke alert above limit
// - enabled overdue thresholds raise partial/full overdue alerts
// - limit alerts clear without hysteresis once no longer above the limit
`default_nettype none
package thm_pkg;
  // register word offsets, byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TRAVEL = 8'h04;
  localparam logic [7:0] ADR_OPEN_PT = 8'h08;
  localparam logic [7:0] ADR_OPEN_DB = 8'h0c;
  localparam logic [7:0] ADR_CLOSED_PT = 8'h10;
  localparam logic [7:0] ADR_CLOSED_DB = 8'h14;
  localparam logic [7:0] ADR_HH = 8'h18;
  localparam logic [7:0] ADR_HI = 8'h1c;
  localparam logic [7:0] ADR_LO = 8'h20;
  localparam logic [7:0] ADR_LL = 8'h24;
  localparam logic [7:0] ADR_REV_CNT = 8'h28;
  localparam logic [7:0] ADR_REV_PT = 8'h2c;
  localparam logic [7:0] ADR_REV_DB = 8'h30;
  localparam logic [7:0] ADR_ACC = 8'h34;
  localparam logic [7:0] ADR_ACC_PT = 8'h38;
  localparam logic [7:0] ADR_ACC_DB = 8'h3c;
  localparam logic [7:0] ADR_STK_A = 8'h40;
  localparam logic [7:0] ADR_STK_B = 8'h44;
  localparam logic [7:0] ADR_STK_A_LIM = 8'h48;
  localparam logic [7:0] ADR_STK_B_LIM = 8'h4c;
  localparam logic [7:0] ADR_PT_ELAPSED = 8'h50;
  localparam logic [7:0] ADR_PT_LIM = 8'h54;
  localparam logic [7:0] ADR_FT_ELAPSED = 8'h58;
  localparam logic [7:0] ADR_FT_LIM = 8'h5c;
  localparam logic [7:0] ADR_STATUS = 8'h60;
  // control word fields
  localparam int CTRL_HH_EN = 9;
  localparam int CTRL_HI_EN = 10;
  localparam int CTRL_LO_EN = 11;
  localparam int CTRL_LL_EN = 12;
  localparam int CTRL_STROKE_LVL = 0;
  localparam int CTRL_PT_EN = 1;
  localparam int CTRL_FT_EN = 2;
  // status bit positions
  localparam int ST_OPEN = 0;
  localparam int ST_CLOSED = 1;
  localparam int ST_HH = 2;
  localparam int ST_HI = 3;
  localparam int ST_LO = 4;
  localparam int ST_LL = 5;
  localparam int ST_REV = 6;
  localparam int ST_ACC = 7;
  localparam int ST_STK_A = 8;
  localparam int ST_STK_B = 9;
  localparam int ST_PT_OVD = 10;
  localparam int ST_FT_OVD = 11;
  localparam int ST_W = 12;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // direction encodings, one-hot
  typedef enum logic [2:0] {
    DIR_NONE = 3'b001,
    DIR_UP = 3'b010,
    DIR_DOWN = 3'b100
  } thm_dir_t;
  // bus reply carrier
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } thm_reply_t;
endpackage
`default_nettype wire

/* thm_monitor.sv */
`default_nettype none
module thm_monitor #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // new travel sample, percent of ranged travel
  input wire logic sampleValid,
  input wire logic [W-1:0] sampleTravel,
  // alert outputs
  output logic [thm_pkg::ST_W-1:0] alertFlags
);
  // whole module state
  typedef struct packed {
    thm_pkg::thm_reply_t bus;
    logic [31:0] ctrl;
    logic [W-1:0] travel;
    logic [W-1:0] openPt, openDb, closedPt, closedDb;
    logic [3:0][W-1:0] proxPt; // hh, hi, lo, ll points
    logic [3:0][W-1:0] proxDb; // matching deadbands
    logic [31:0] revCnt, revPt;
    logic [W-1:0] revDb, revRef;
    thm_pkg::thm_dir_t dir; // last direction seen outside the deadband
    logic [31:0] acc, accPt;
    logic [W-1:0] accDb, accRef;
    logic [31:0] stkA, stkB, stkALim, stkBLim;
    logic [31:0] ptElapsed, ptLim, ftElapsed, ftLim;
    logic [thm_pkg::ST_W-1:0] alerts;
  } thm_state_t;

  thm_state_t s_q, s_d;
  logic wrHit; // write accepted this cycle
  logic [31:0] wv; // write value after byte lanes
  logic [31:0] rd; // read mux
  logic [W-1:0] t; // working travel
  logic [W:0] bandLo, bandHi; // proximity band edges
  logic [W-1:0] diff; // distance from reference

  // byte lane merge against the addressed register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // read mux over the register map
  always_comb begin
    rd = thm_pkg::RST_ZERO;
    unique case (wb_adr_i)
      thm_pkg::ADR_CTRL: rd = s_q.ctrl;
      thm_pkg::ADR_TRAVEL: rd = 32'(s_q.travel);
      thm_pkg::ADR_OPEN_PT: rd = 32'(s_q.openPt);
      thm_pkg::ADR_OPEN_DB: rd = 32'(s_q.openDb);
      thm_pkg::ADR_CLOSED_PT: rd = 32'(s_q.closedPt);
      thm_pkg::ADR_CLOSED_DB: rd = 32'(s_q.closedDb);
      thm_pkg::ADR_HH: rd = 32'({s_q.proxDb[0], s_q.proxPt[0]});
      thm_pkg::ADR_HI: rd = 32'({s_q.proxDb[1], s_q.proxPt[1]});
      thm_pkg::ADR_LO: rd = 32'({s_q.proxDb[2], s_q.proxPt[2]});
      thm_pkg::ADR_LL: rd = 32'({s_q.proxDb[3], s_q.proxPt[3]});
      thm_pkg::ADR_REV_CNT: rd = s_q.revCnt;
      thm_pkg::ADR_REV_PT: rd = s_q.revPt;
      thm_pkg::ADR_REV_DB: rd = 32'(s_q.revDb);
      thm_pkg::ADR_ACC: rd = s_q.acc;
      thm_pkg::ADR_ACC_PT: rd = s_q.accPt;
      thm_pkg::ADR_ACC_DB: rd = 32'(s_q.accDb);
      thm_pkg::ADR_STK_A: rd = s_q.stkA;
      thm_pkg::ADR_STK_B: rd = s_q.stkB;
      thm_pkg::ADR_STK_A_LIM: rd = s_q.stkALim;
      thm_pkg::ADR_STK_B_LIM: rd = s_q.stkBLim;
      thm_pkg::ADR_PT_ELAPSED: rd = s_q.ptElapsed;
      thm_pkg::ADR_PT_LIM: rd = s_q.ptLim;
      thm_pkg::ADR_FT_ELAPSED: rd = s_q.ftElapsed;
      thm_pkg::ADR_FT_LIM: rd = s_q.ftLim;
      thm_pkg::ADR_STATUS: rd = 32'(s_q.alerts);
      default: rd = thm_pkg::RST_ZERO; // unmapped reads zero
    endcase
  end

  // next-state logic: bus, travel evaluation, alerts
  always_comb begin
    s_d = s_q;
    bandLo = '0;
    bandHi = '0;
    diff = '0;
    wrHit = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.bus.ack;
    wv = '0;
    t = s_q.travel;
    // bus reply, one cycle after request, dropped the next
    s_d.bus.ack = wb_cyc_i && wb_stb_i && !s_q.bus.ack;
    s_d.bus.dat = rd;
    // register writes
    if (wrHit) begin
      unique case (wb_adr_i)
        thm_pkg::ADR_CTRL: s_d.ctrl = merge(s_q.ctrl, wb_dat_i, wb_sel_i);
        thm_pkg::ADR_OPEN_PT: begin
          wv = merge(32'(s_q.openPt), wb_dat_i, wb_sel_i);
          s_d.openPt = wv[W-1:0];
        end
        thm_pkg::ADR_OPEN_DB: begin
          wv = merge(32'(s_q.openDb), wb_dat_i, wb_sel_i);
          s_d.openDb = wv[W-1:0];
        end
        thm_pkg::ADR_CLOSED_PT: begin
          wv = merge(32'(s_q.closedPt), wb_dat_i, wb_sel_i);
          s_d.closedPt = wv[W-1:0];
        end
        thm_pkg::ADR_CLOSED_DB: begin
          wv = merge(32'(s_q.closedDb), wb_dat_i, wb_sel_i);
          s_d.closedDb = wv[W-1:0];
        end
        thm_pkg::ADR_HH, thm_pkg::ADR_HI, thm_pkg::ADR_LO, thm_pkg::ADR_LL: begin
          for (int k = 0; k < 4; k++) begin
            if (wb_adr_i == thm_pkg::ADR_HH + 8'(4 * k)) begin
              wv = merge(32'({s_q.proxDb[k], s_q.proxPt[k]}), wb_dat_i, wb_sel_i);
              s_d.proxPt[k] = wv[W-1:0];
              s_d.proxDb[k] = wv[2*W-1:W];
            end
          end
        end
        thm_pkg::ADR_REV_CNT: begin
          s_d.revCnt = merge(s_q.revCnt, wb_dat_i, wb_sel_i);
          s_d.revRef = s_q.travel;
          s_d.dir = thm_pkg::DIR_NONE;
        end
        thm_pkg::ADR_REV_PT: s_d.revPt = merge(s_q.revPt, wb_dat_i, wb_sel_i);
        thm_pkg::ADR_REV_DB: begin
          wv = merge(32'(s_q.revDb), wb_dat_i, wb_sel_i);
          s_d.revDb = wv[W-1:0];
        end
        thm_pkg::ADR_ACC: begin
          s_d.acc = merge(s_q.acc, wb_dat_i, wb_sel_i);
          s_d.accRef = s_q.travel;
        end
        thm_pkg::ADR_ACC_PT: s_d.accPt = merge(s_q.accPt, wb_dat_i, wb_sel_i);
        thm_pkg::ADR_ACC_DB: begin
          wv = merge(32'(s_q.accDb), wb_dat_i, wb_sel_i);
          s_d.accDb = wv[W-1:0];
        end
        thm_pkg::ADR_STK_A: s_d.stkA = merge(s_q.stkA, wb_dat_i, wb_sel_i);
        thm_pkg::ADR_STK_B: s_d.stkB = merge(s_q.stkB, wb_dat_i, wb_sel_i);
        thm_pkg::ADR_STK_A_LIM: s_d.stkALim = merge(s_q.stkALim, wb_dat_i, wb_sel_i);
        thm_pkg::ADR_STK_B_LIM: s_d.stkBLim = merge(s_q.stkBLim, wb_dat_i, wb_sel_i);
        thm_pkg::ADR_PT_ELAPSED: s_d.ptElapsed = merge(s_q.ptElapsed, wb_dat_i, wb_sel_i);
        thm_pkg::ADR_PT_LIM: s_d.ptLim = merge(s_q.ptLim, wb_dat_i, wb_sel_i);
        thm_pkg::ADR_FT_ELAPSED: s_d.ftElapsed = merge(s_q.ftElapsed, wb_dat_i, wb_sel_i);
        thm_pkg::ADR_FT_LIM: s_d.ftLim = merge(s_q.ftLim, wb_dat_i, wb_sel_i);
        default: ; // read-only or unmapped: ignored
      endcase
    end
    // travel sample processing
    if (sampleValid) begin
      t = sampleTravel;
      s_d.travel = sampleTravel;
      // open end-stop with clearing deadband
      if (t > s_q.openPt) begin
        s_d.alerts[thm_pkg::ST_OPEN] = 1'b1;
      end else if (32'(t) + 32'(s_q.openDb) < 32'(s_q.openPt)) begin
        s_d.alerts[thm_pkg::ST_OPEN] = 1'b0;
      end
      // closed end-stop with clearing deadband
      if (t < s_q.closedPt) begin
        s_d.alerts[thm_pkg::ST_CLOSED] = 1'b1;
      end else if (32'(t) > 32'(s_q.closedPt) + 32'(s_q.closedDb)) begin
        s_d.alerts[thm_pkg::ST_CLOSED] = 1'b0;
      end
      // reversal detection outside the deadband around the reference
      diff = (t > s_q.revRef) ? t - s_q.revRef : s_q.revRef - t;
      if (diff > s_q.revDb) begin
        if (t > s_q.revRef) begin
          if (s_q.dir == thm_pkg::DIR_DOWN) begin
            s_d.revCnt = s_q.revCnt + 32'h0000_0001;
          end
          s_d.dir = thm_pkg::DIR_UP;
        end else begin
          if (s_q.dir == thm_pkg::DIR_UP) begin
            s_d.revCnt = s_q.revCnt + 32'h0000_0001;
          end
          s_d.dir = thm_pkg::DIR_DOWN;
        end
        s_d.revRef = t;
      end
      // travel accumulation beyond the deadband
      diff = (t > s_q.accRef) ? t - s_q.accRef : s_q.accRef - t;
      if (diff > s_q.accDb) begin
        s_d.acc = s_q.acc + 32'(diff);
        s_d.accRef = t;
      end
    end
    // proximity bands: point plus or minus deadband, gated by enable
    for (int k = 0; k < 4; k++) begin
      bandLo = ({1'b0, s_q.proxPt[k]} > {1'b0, s_q.proxDb[k]}) ?
               {1'b0, s_q.proxPt[k]} - {1'b0, s_q.proxDb[k]} : '0;
      bandHi = {1'b0, s_q.proxPt[k]} + {1'b0, s_q.proxDb[k]};
      s_d.alerts[thm_pkg::ST_HH + k] = s_q.ctrl[thm_pkg::CTRL_HH_EN + k] &&
          ({1'b0, s_q.travel} >= bandLo) && ({1'b0, s_q.travel} <= bandHi);
    end
    // reversal and accumulator alerts: set above point, clear on rewrite below
    // a rewrite below the point wins over the stale count it replaces
    if (wrHit && wb_adr_i == thm_pkg::ADR_REV_CNT && s_d.revCnt < s_q.revPt) begin
      s_d.alerts[thm_pkg::ST_REV] = 1'b0;
    end else if (s_q.revCnt > s_q.revPt) begin
      s_d.alerts[thm_pkg::ST_REV] = 1'b1;
    end
    if (wrHit && wb_adr_i == thm_pkg::ADR_ACC && s_d.acc < s_q.accPt) begin
      s_d.alerts[thm_pkg::ST_ACC] = 1'b0;
    end else if (s_q.acc > s_q.accPt) begin
      s_d.alerts[thm_pkg::ST_ACC] = 1'b1;
    end
    // stroke times: slot A is opening or demand, slot B closing or reset
    // level bit only relabels the slots, comparison is shared
    s_d.alerts[thm_pkg::ST_STK_A] = s_q.stkA > s_q.stkALim;
    s_d.alerts[thm_pkg::ST_STK_B] = s_q.stkB > s_q.stkBLim;
    // stroke test overdue checks
    s_d.alerts[thm_pkg::ST_PT_OVD] = s_q.ctrl[thm_pkg::CTRL_PT_EN] &&
                                    (s_q.ptElapsed > s_q.ptLim);
    s_d.alerts[thm_pkg::ST_FT_OVD] = s_q.ctrl[thm_pkg::CTRL_FT_EN] &&
                                    (s_q.ftElapsed > s_q.ftLim);
  end

  // state register, reset clears all but dir, which loads DIR_NONE
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
      s_q.dir <= thm_pkg::DIR_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign wb_ack_o = s_q.bus.ack;
  assign wb_dat_o = s_q.bus.dat;
  assign alertFlags = s_q.alerts;
endmodule
`default_nettype wire

/* thm_monitor_assertions.sv */
`default_nettype none
module thm_monitor_assertions #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // bus side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // samples and alerts
  input wire logic sampleValid,
  input wire logic [W-1:0] sampleTravel,
  input wire logic [thm_pkg::ST_W-1:0] alertFlags
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // a write that the slave answered one edge ago
  sequence s_wr_done;
    $past(wb_ack_o && wb_we_i);
  endsequence
  // a taken request: one ack pulse, then quiet
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_walk: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse)
    else $error("bus answer is not a single pulse one cycle later");
  a_reset_clear: assert property ($past(srst) |-> alertFlags == '0 && !wb_ack_o)
    else $error("alerts or ack not cleared by reset");
  a_open_sample: assert property ($changed(alertFlags[thm_pkg::ST_OPEN]) |-> $past(sampleValid))
    else $error("open alert moved without a sample");
  a_closed_sample: assert property ($changed(alertFlags[thm_pkg::ST_CLOSED])
    |-> $past(sampleValid))
    else $error("closed alert moved without a sample");
  a_prox_cause: assert property ($changed(alertFlags[5:2])
    |-> $past(sampleValid, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("proximity alert moved without sample or write");
  a_rev_rise: assert property ($rose(alertFlags[thm_pkg::ST_REV])
    |-> $past(sampleValid, 2) or s_wr_done)
    else $error("reversal alert rose without cause");
  a_rev_clear: assert property ($fell(alertFlags[thm_pkg::ST_REV])
    |-> wb_ack_o && wb_we_i)
    else $error("reversal alert fell without a write");
  a_acc_clear: assert property ($fell(alertFlags[thm_pkg::ST_ACC])
    |-> wb_ack_o && wb_we_i)
    else $error("accumulator alert fell without a write");
  a_stroke_write: assert property ($changed(alertFlags[9:8]) |-> s_wr_done)
    else $error("stroke alert moved without a write");
  a_overdue_write: assert property ($changed(alertFlags[11:10]) |-> s_wr_done)
    else $error("overdue alert moved without a write");
endmodule
bind thm_monitor thm_monitor_assertions #(.W(W)) i_chk (.clk_sys(clk_sys), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sampleValid(sampleValid), .sampleTravel(sampleTravel), .alertFlags(alertFlags));
`default_nettype wire

/* thm_monitor_tb.sv */
`default_nettype none
module thm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic sv = 1'b0;
  logic [15:0] st = 16'h0000;
  // design outputs
  logic [31:0] rdat;
  logic ack;
  logic [11:0] flags;
  // model: register image, references, expected flags
  int cfg [0:31] = '{default: 0};
  int tv [14] = '{50, 81, 90, 78, 74, 88, 70, 68, 30, 19, 22, 26, 3, 0};
  int rRef = 0, aRef = 0, rDir = 0, seed = 97, nFail = 0, testsRun = 0, cycN = 0;
  logic [11:0] ef = 12'h000;
  logic [31:0] rv;
  thm_monitor #(.W(16)) i_dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sampleValid(sv), .sampleTravel(st), .alertFlags(flags));
  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cycN <= cycN + 1;
    if (cycN == 30000) begin
      nFail++;
      finish_test();
    end
  end
  task automatic chk_bus(input logic [31:0] g, input logic [31:0] e);
    testsRun++;
    if (g !== e) begin
      nFail++;
      $display("CHECK FAILED t=%0t read %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_flags(input logic [11:0] g, input logic [11:0] e);
    testsRun++;
    if (g !== e) begin
      nFail++;
      $display("CHECK FAILED t=%0t flags %h exp %h", $time, g, e);
    end
  endtask
  // expected alert levels from the register image, then compare
  task automatic upd();
    int p, db;
    for (int i = 0; i < 4; i++) begin
      p = cfg[6+i] & 32'h0000_ffff;
      db = cfg[6+i] >> 16;
      ef[2+i] = cfg[0][9+i] && cfg[1] <= p + db && cfg[1] >= (p > db ? p - db : 0);
    end
    ef[6] = ef[6] || cfg[10] > cfg[11];
    ef[7] = ef[7] || cfg[13] > cfg[14];
    ef[8] = cfg[16] > cfg[18];
    ef[9] = cfg[17] > cfg[19];
    ef[10] = cfg[0][1] && cfg[20] > cfg[21];
    ef[11] = cfg[0][2] && cfg[22] > cfg[23];
    repeat (3) @(posedge clk_sys);
    chk_flags(flags, ef);
  endtask
  // one classic cycle; image follows writes to mapped writable words
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    if (w && a == 8'h28 && d < cfg[11]) ef[6] = 1'b0;
    if (w && a == 8'h34 && d < cfg[14]) ef[7] = 1'b0;
    if (w && a == 8'h28) rDir = 0;
    if (w && a == 8'h28) rRef = cfg[1];
    if (w && a == 8'h34) aRef = cfg[1];
    if (w && a != 8'h04 && a < 8'h60) cfg[a[6:2]] = d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    upd();
  endtask
  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 32'h0000_0000);
    chk_bus(rv, a == 8'h60 ? {20'h0_0000, ef} : (a < 8'h60 ? cfg[a[6:2]] : 0));
  endtask
  // one travel sample through the end-stop, reversal and accumulator model
  task automatic samp(input int t);
    int dl, nd;
    @(posedge clk_sys);
    sv <= 1'b1;
    st <= t[15:0];
    @(posedge clk_sys);
    sv <= 1'b0;
    cfg[1] = t;
    if (t > cfg[2]) ef[0] = 1'b1;
    else if (t + cfg[3] < cfg[2]) ef[0] = 1'b0;
    if (t < cfg[4]) ef[1] = 1'b1;
    else if (t > cfg[4] + cfg[5]) ef[1] = 1'b0;
    dl = t - rRef;
    if (dl > cfg[12] || -dl > cfg[12]) begin
      nd = dl > 0 ? 1 : 2;
      if (rDir != 0 && nd != rDir) cfg[10]++;
      rRef = t;
      rDir = nd;
    end
    dl = t - aRef;
    if (dl > cfg[15] || -dl > cfg[15]) begin
      cfg[13] += dl < 0 ? -dl : dl;
      aRef = t;
    end
    upd();
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    for (int a = 0; a < 104; a += 4) rd(a[7:0]);
    wr(8'h04, 32'h0000_0033);
    wr(8'h80, 32'h0000_0001);
    rd(8'h04);
    rd(8'h80);
    wr(8'h08, 80);
    wr(8'h0c, 5);
    wr(8'h10, 20);
    wr(8'h14, 5);
    wr(8'h18, 32'h0003_005a);
    wr(8'h1c, 32'h0002_0046);
    wr(8'h20, 32'h0004_001e);
    wr(8'h24, 32'h0008_0005);
    wr(8'h2c, 2);
    wr(8'h30, 3);
    wr(8'h38, 100);
    wr(8'h3c, 4);
    for (int e = 0; e < 2; e++) begin
      wr(8'h00, e ? 32'h0000_1e00 : 32'h0000_0000);
      foreach (tv[i]) samp(tv[i]);
    end
    rd(8'h28);
    rd(8'h34);
    wr(8'h2c, 50);
    wr(8'h28, 0);
    wr(8'h34, 0);
    samp(40);
    samp(10);
    rd(8'h28);
    rd(8'h34);
    wr(8'h48, 32'h0000_8000);
    wr(8'h4c, 32'h0000_8000);
    wr(8'h54, 9);
    wr(8'h5c, 9);
    for (int l = 0; l < 8; l++) begin
      wr(8'h00, l);
      wr(8'h40, $random(seed) & 32'h0000_ffff);
      wr(8'h44, $random(seed) & 32'h0000_ffff);
      wr(8'h50, l * 3);
      wr(8'h58, l * 3);
    end
    rd(8'h60);
    finish_test();
  end
endmodule
`default_nettype wire
